// ---- src/irq_entry_pkg.sv ----
// Purpose: shared constants for the interrupt entry and return block
// Assumes: 32-bit apb data, one word per register, 16-bit program counter
// Notes: source index 0 is external_request_zero, the highest vectored priority
package irq_entry_pkg;
  localparam int NUM_FLAG = 4;
  localparam int NUM_LEVEL = 2;
  localparam int NUM_SRC = NUM_FLAG + NUM_LEVEL;
  localparam int IDX_W = 3;
  localparam int PC_W = 16;
  localparam int SP_W = 16;

  // apb register byte offsets
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_ENABLE = 12'h004;
  localparam logic [11:0] OFF_FLAGS = 12'h008;
  localparam logic [11:0] OFF_MCU_CTRL = 12'h00c;
  localparam logic [11:0] OFF_ZPAGE = 12'h010;
  localparam logic [11:0] OFF_STACK = 12'h014;
  localparam logic [11:0] OFF_STATE = 12'h018;

  // field positions
  localparam int GIE_BIT = 7;
  localparam int RELOC_BIT = 1;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [NUM_SRC-1:0] ENABLE_RST = '0;
  localparam logic [7:0] ZPAGE_RST = 8'h00;
  localparam logic [SP_W-1:0] SP_RST = 16'h0aff;

  // program memory layout
  localparam logic [PC_W-1:0] VEC_BASE_APP = 16'h0000;
  localparam logic [PC_W-1:0] BOOT_START_DEF = 16'h3800;
  localparam logic [PC_W-1:0] VEC_STRIDE = 16'h0002;

  // cycle and byte figures
  localparam logic [2:0] ENTRY_CYCLES = 3'h5;
  localparam logic [2:0] RETURN_CYCLES = 3'h5;
  localparam logic [2:0] WAKE_CYCLES = 3'h5;
  localparam logic [2:0] PC_BYTES = 3'h3;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAKE,
    ST_ENTRY,
    ST_RETURN
  } seq_state_t;
endpackage : irq_entry_pkg

// ---- src/irq_entry_return.sv ----
// Purpose: interrupt gating, priority, vector entry and return sequencing
// Assumes: pipeline pulses instr_done on the last cycle of each instruction
// Notes: registers reached over apb with no wait state: pready rises in the first access cycle
//
// Added by the designer: the APB register port and the placing of the registers.
module irq_entry_return #(
  parameter logic [15:0] BOOT_START = irq_entry_pkg::BOOT_START_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [irq_entry_pkg::NUM_FLAG-1:0] flag_event,
  input wire logic [irq_entry_pkg::NUM_LEVEL-1:0] level_req,
  input wire logic instr_done,
  input wire logic instr_sei,
  input wire logic instr_cli,
  input wire logic instr_irq_ret,
  input wire logic sleeping,
  input wire logic [irq_entry_pkg::PC_W-1:0] cur_pc,
  input wire logic boot_reset_fuse,
  input wire logic app_boot_lock_bit,
  input wire logic boot_section_lock_bit,
  input wire logic [7:0] stk_rdata,
  input wire logic extended_program_load,
  input wire logic self_program_store,
  input wire logic [7:0] z_high_byte,
  input wire logic [7:0] z_low_byte,
  output logic cpu_hold,
  output logic pc_load,
  output logic [irq_entry_pkg::PC_W-1:0] pc_load_addr,
  output logic [irq_entry_pkg::PC_W-1:0] reset_vector,
  output logic stk_we,
  output logic stk_re,
  output logic [irq_entry_pkg::SP_W-1:0] stk_addr,
  output logic [7:0] stk_wdata,
  output logic [23:0] prog_addr
);
  import irq_entry_pkg::*;

  logic [7:0] status_flags_reg_r;
  logic [NUM_SRC-1:0] enable_r;
  logic [NUM_FLAG-1:0] flags_r;
  logic [7:0] mcu_control_reg_r;
  logic [7:0] z_pointer_page_extension_r;
  logic [SP_W-1:0] sp_r;
  seq_state_t state_r;
  logic [2:0] cnt_r;
  logic [IDX_W-1:0] src_idx_r;
  logic [PC_W-1:0] saved_pc_r;
  logic [PC_W-1:0] ret_pc_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic cpu_hold_r;
  logic pc_load_r;
  logic [PC_W-1:0] pc_load_addr_r;
  logic [PC_W-1:0] reset_vector_r;
  logic stk_we_r;
  logic stk_re_r;
  logic [SP_W-1:0] stk_addr_r;
  logic [7:0] stk_wdata_r;
  logic [23:0] prog_addr_r;

  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic gie;
  logic [NUM_SRC-1:0] pending;
  logic any_pend;
  logic [IDX_W-1:0] win_idx;
  logic in_app;
  logic suppress;
  logic boundary;
  logic take;
  logic [PC_W-1:0] vec_base;
  logic [PC_W-1:0] vec_addr;
  logic [NUM_FLAG-1:0] hw_clr;
  logic [NUM_FLAG-1:0] sw_clr;
  logic seq_last;
  logic ret_done;
  logic entry_done;

  assign gie = status_flags_reg_r[GIE_BIT];

  // apb decode: setup captures read data, access phase completes
  assign wr_en = psel && penable && pready_r && pwrite && addr_ok;
  assign rd_setup = psel && !penable;
  always_comb begin
    case (paddr)
      OFF_STATUS, OFF_ENABLE, OFF_FLAGS, OFF_MCU_CTRL,
      OFF_ZPAGE, OFF_STACK, OFF_STATE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_r <= rd_setup;
      pslverr_r <= rd_setup && !addr_ok;
      if (rd_setup) begin
        case (paddr)
          OFF_STATUS: prdata_r <= {24'h000000, status_flags_reg_r};
          OFF_ENABLE: prdata_r <= {{(32-NUM_SRC){1'b0}}, enable_r};
          OFF_FLAGS: prdata_r <= {{(32-NUM_SRC){1'b0}}, level_req, flags_r};
          OFF_MCU_CTRL: prdata_r <= {24'h000000, mcu_control_reg_r};
          OFF_ZPAGE: prdata_r <= {24'h000000, z_pointer_page_extension_r};
          OFF_STACK: prdata_r <= {16'h0000, sp_r};
          OFF_STATE: prdata_r <= {24'h000000, 1'b0, src_idx_r, 2'b00, state_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // pending requests and fixed priority
  assign pending = {level_req, flags_r} & enable_r;
  assign any_pend = |pending;
  always_comb begin
    win_idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        win_idx = IDX_W'(i);
      end
    end
  end

  // boot lock suppression depends on which section is executing
  assign in_app = cur_pc < BOOT_START;
  assign suppress = (app_boot_lock_bit && in_app && mcu_control_reg_r[RELOC_BIT]) ||
                    (boot_section_lock_bit && !in_app && !mcu_control_reg_r[RELOC_BIT]);

  // cli in the boundary cycle blocks; sei lands at this edge so old gie blocks
  assign boundary = (instr_done && !instr_cli && !instr_irq_ret) ||
                    sleeping;
  assign take = clk_en && state_r == ST_RUN && gie && any_pend && !suppress &&
                boundary;

  assign vec_base = mcu_control_reg_r[RELOC_BIT] ? BOOT_START : VEC_BASE_APP;
  assign vec_addr = vec_base + PC_W'(({13'h0000, src_idx_r} + 16'h0001) * VEC_STRIDE);

  assign seq_last = cnt_r == 3'h1;
  assign entry_done = clk_en && state_r == ST_ENTRY && seq_last;
  assign ret_done = clk_en && state_r == ST_RETURN && seq_last;

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      cnt_r <= 3'h0;
      src_idx_r <= '0;
      saved_pc_r <= '0;
    end else if (clk_en) begin
      case (state_r)
        ST_RUN: begin
          if (take) begin
            src_idx_r <= win_idx;
            saved_pc_r <= cur_pc;
            state_r <= sleeping ? ST_WAKE : ST_ENTRY;
            cnt_r <= sleeping ? WAKE_CYCLES : ENTRY_CYCLES;
          end else if (instr_done && instr_irq_ret) begin
            state_r <= ST_RETURN;
            cnt_r <= RETURN_CYCLES;
          end
        end
        ST_WAKE: begin
          cnt_r <= seq_last ? ENTRY_CYCLES : cnt_r - 3'h1;
          if (seq_last) begin
            state_r <= ST_ENTRY;
          end
        end
        ST_ENTRY, ST_RETURN: begin
          cnt_r <= cnt_r - 3'h1;
          if (seq_last) begin
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // stack traffic: pc low, pc high, then a zero third byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stk_we_r <= 1'b0;
      stk_re_r <= 1'b0;
      stk_addr_r <= '0;
      stk_wdata_r <= 8'h00;
      ret_pc_r <= '0;
    end else if (clk_en) begin
      stk_we_r <= 1'b0;
      stk_re_r <= 1'b0;
      if (state_r == ST_ENTRY && cnt_r > (ENTRY_CYCLES - PC_BYTES)) begin
        stk_we_r <= 1'b1;
        stk_addr_r <= sp_r - SP_W'(ENTRY_CYCLES - cnt_r);
        case (ENTRY_CYCLES - cnt_r)
          3'h0: stk_wdata_r <= saved_pc_r[7:0];
          3'h1: stk_wdata_r <= saved_pc_r[15:8];
          default: stk_wdata_r <= 8'h00;
        endcase
      end
      if (state_r == ST_RETURN && cnt_r > (RETURN_CYCLES - PC_BYTES)) begin
        stk_re_r <= 1'b1;
        stk_addr_r <= sp_r + SP_W'(RETURN_CYCLES - cnt_r + 3'h1);
      end
      if (stk_re_r) begin
        ret_pc_r <= {ret_pc_r[7:0], stk_rdata}; // third pop holds the low byte last
      end
    end
  end

  // stack pointer and program counter redirection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= SP_RST;
      pc_load_r <= 1'b0;
      pc_load_addr_r <= '0;
      cpu_hold_r <= 1'b0;
    end else if (clk_en) begin
      pc_load_r <= entry_done || ret_done;
      cpu_hold_r <= take || (state_r != ST_RUN && !seq_last) ||
                    (state_r == ST_WAKE) || (state_r == ST_RUN && instr_done && instr_irq_ret);
      if (entry_done) begin
        sp_r <= sp_r - SP_W'(PC_BYTES);
        pc_load_addr_r <= vec_addr;
      end else if (ret_done) begin
        sp_r <= sp_r + SP_W'(PC_BYTES);
        pc_load_addr_r <= ret_pc_r;
      end else if (wr_en && paddr == OFF_STACK) begin
        sp_r <= pwdata[SP_W-1:0];
      end
    end
  end

  // status register: only the global enable bit is touched by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags_reg_r <= STATUS_RST;
    end else if (clk_en) begin
      if (wr_en && paddr == OFF_STATUS) begin
        status_flags_reg_r <= pwdata[7:0];
      end
      if (instr_done && instr_sei) begin
        status_flags_reg_r[GIE_BIT] <= 1'b1;
      end
      if (instr_done && instr_cli) begin
        status_flags_reg_r[GIE_BIT] <= 1'b0;
      end
      if (take) begin
        status_flags_reg_r[GIE_BIT] <= 1'b0;
      end
      if (ret_done) begin
        status_flags_reg_r[GIE_BIT] <= 1'b1;
      end
    end
  end

  // flags: events win over both clears
  assign hw_clr = (take && win_idx < IDX_W'(NUM_FLAG)) ?
                  NUM_FLAG'(1) << win_idx : '0;
  assign sw_clr = (wr_en && paddr == OFF_FLAGS) ? pwdata[NUM_FLAG-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= '0;
    end else if (clk_en) begin
      flags_r <= (flags_r & ~hw_clr & ~sw_clr) | flag_event;
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= ENABLE_RST;
      mcu_control_reg_r <= 8'h00;
      z_pointer_page_extension_r <= ZPAGE_RST;
    end else if (clk_en && wr_en) begin
      case (paddr)
        OFF_ENABLE: enable_r <= pwdata[NUM_SRC-1:0];
        OFF_MCU_CTRL: mcu_control_reg_r <= pwdata[7:0];
        OFF_ZPAGE: z_pointer_page_extension_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // reset vector and program memory pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_vector_r <= VEC_BASE_APP;
      prog_addr_r <= 24'h000000;
    end else if (clk_en) begin
      reset_vector_r <= boot_reset_fuse ? BOOT_START : VEC_BASE_APP;
      if (extended_program_load || self_program_store) begin
        prog_addr_r <= {z_pointer_page_extension_r, z_high_byte, z_low_byte};
      end else begin
        prog_addr_r <= {8'h00, z_high_byte, z_low_byte};
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cpu_hold = cpu_hold_r;
  assign pc_load = pc_load_r;
  assign pc_load_addr = pc_load_addr_r;
  assign reset_vector = reset_vector_r;
  assign stk_we = stk_we_r;
  assign stk_re = stk_re_r;
  assign stk_addr = stk_addr_r;
  assign stk_wdata = stk_wdata_r;
  assign prog_addr = prog_addr_r;

  // checks assume clk_en stays high
  sequence s_entry_hold;
    state_r == ST_ENTRY [*5];
  endsequence
  sequence s_vector_out;
    pc_load_r && pc_load_addr_r == $past(vec_addr);
  endsequence

  property p_gie_clear;
    @(posedge pclk) disable iff (!presetn)
      take |=> !status_flags_reg_r[GIE_BIT];
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("gie not cleared on entry");

  property p_enable_gate;
    @(posedge pclk) disable iff (!presetn)
      take |-> gie && enable_r[win_idx] && !suppress;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("ungated take");

  property p_priority;
    @(posedge pclk) disable iff (!presetn)
      take |-> (pending & ((NUM_SRC'(1) << win_idx) - NUM_SRC'(1))) == '0;
  endproperty
  a_priority: assert property (p_priority) else $error("lower priority taken");

  property p_entry_len;
    @(posedge pclk) disable iff (!presetn)
      (take && !sleeping) |=> s_entry_hold ##1 s_vector_out;
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry not five cycles");

  property p_wake_len;
    @(posedge pclk) disable iff (!presetn)
      (take && sleeping) |=> (state_r == ST_WAKE) [*5] ##1 s_entry_hold;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake delay wrong");

  property p_sp_dec;
    @(posedge pclk) disable iff (!presetn)
      entry_done |=> sp_r == $past(sp_r) - SP_W'(PC_BYTES);
  endproperty
  a_sp_dec: assert property (p_sp_dec) else $error("sp not lowered by three");

  property p_return;
    @(posedge pclk) disable iff (!presetn)
      (state_r == ST_RUN && instr_done && instr_irq_ret) |=> (state_r == ST_RETURN) [*5]
        ##1 (gie && pc_load_r && sp_r == $past(sp_r, 6) + SP_W'(PC_BYTES));
  endproperty
  a_return: assert property (p_return) else $error("return sequence wrong");

  property p_cli_block;
    @(posedge pclk) disable iff (!presetn)
      (instr_done && instr_cli) |-> !take ##1 !gie;
  endproperty
  a_cli_block: assert property (p_cli_block) else $error("taken across cli");

  property p_sei_delay;
    @(posedge pclk) disable iff (!presetn)
      (instr_done && instr_sei && !gie) |-> !take;
  endproperty
  a_sei_delay: assert property (p_sei_delay) else $error("taken right after sei");

  property p_flag_set_wins;
    @(posedge pclk) disable iff (!presetn)
      (|flag_event) |=> (flags_r & $past(flag_event)) == $past(flag_event);
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag event lost");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFF_FLAGS && flag_event == '0) |=>
        flags_r == ($past(flags_r) & ~$past(pwdata[NUM_FLAG-1:0]) & ~$past(hw_clr));
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag write one clear wrong");

  property p_zptr;
    @(posedge pclk) disable iff (!presetn)
      (!extended_program_load && !self_program_store) |=> prog_addr_r[23:16] == 8'h00;
  endproperty
  a_zptr: assert property (p_zptr) else $error("plain load used page");
endmodule : irq_entry_return

// ---- tb/stack_model.sv ----
// Purpose: byte-wide stack memory standing behind the interrupt sequencer
// Assumes: read data follows the address while the read strobe is high
// Notes: outside a read the data lines toggle so stale values never match
module stack_model (
  input wire logic pclk,
  input wire logic stk_we,
  input wire logic stk_re,
  input wire logic [15:0] stk_addr,
  input wire logic [7:0] stk_wdata,
  output logic [7:0] stk_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last_r = 8'h00;

  // pushes land one byte per strobe
  always @(posedge pclk) begin
    if (stk_we === 1'b1) begin
      mem[stk_addr] <= stk_wdata;
    end
    last_r <= stk_rdata;
  end

  // read data stands while the strobe is high, otherwise the inverse of the last value
  assign stk_rdata = (stk_re === 1'b1) ? mem[stk_addr] : ~last_r;
endmodule : stack_model

// ---- tb/cpu_interrupt_entry_return_bench.sv ----
// Purpose: self-checking bench for the interrupt entry and return block
// Assumes: apb master and pipeline strobes driven just after rising edges
// Notes: register rows first, then entry, nesting, return and reset cases
module cpu_interrupt_entry_return_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_entry_pkg::*;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, cpu_hold, pc_load, stk_we, stk_re;
  logic [3:0] flag_event = 4'h0;
  logic [1:0] level_req = 2'h0;
  logic instr_done = 0, instr_sei = 0, instr_cli = 0, instr_irq_ret = 0;
  logic [15:0] cur_pc = 16'h0123, pc_load_addr, reset_vector, stk_addr, a;
  logic boot_reset_fuse = 0, ext_load = 0;
  logic sleeping = 0, app_lock = 0, boot_lock = 0, sps = 0;
  logic [7:0] stk_rdata, stk_wdata, z_hi = 8'h12, z_lo = 8'h34;
  logic [23:0] prog_addr;
  int errors = 0, cmp_count = 0, cycles = 0, n, h;
  row_t rows[17];

  always #10 pclk = ~pclk;

  irq_entry_return u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flag_event(flag_event), .level_req(level_req),
    .instr_done(instr_done), .instr_sei(instr_sei), .instr_cli(instr_cli),
    .instr_irq_ret(instr_irq_ret), .sleeping(sleeping), .cur_pc(cur_pc),
    .boot_reset_fuse(boot_reset_fuse), .app_boot_lock_bit(app_lock),
    .boot_section_lock_bit(boot_lock), .stk_rdata(stk_rdata), .extended_program_load(ext_load),
    .self_program_store(sps), .z_high_byte(z_hi), .z_low_byte(z_lo), .cpu_hold(cpu_hold),
    .pc_load(pc_load), .pc_load_addr(pc_load_addr), .reset_vector(reset_vector),
    .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
    .prog_addr(prog_addr));

  stack_model u_stack (.pclk(pclk), .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));

  task end_sim;
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // one instruction boundary, then watch for a new program counter
  task step(input logic s, input logic c, input logic rt, input logic sl = 1'b0);
    @(posedge pclk);
    instr_done <= !sl;
    instr_sei <= s;
    instr_cli <= c;
    instr_irq_ret <= rt;
    sleeping <= sl;
    @(posedge pclk);
    instr_done <= 0;
    instr_sei <= 0;
    instr_cli <= 0;
    instr_irq_ret <= 0;
    sleeping <= 0;
    n = 0;
    h = 0;
    do begin
      @(posedge pclk);
      n++;
      if (cpu_hold === 1'b1) h++;
    end while (pc_load !== 1'b1 && n < 14);
    a = (pc_load === 1'b1) ? pc_load_addr : 16'hffff;
  endtask : step

  task pulse(input logic [3:0] f);
    @(posedge pclk);
    flag_event <= f;
    @(posedge pclk);
    flag_event <= 4'h0;
  endtask : pulse

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    rows = '{'{1, OFF_STATUS, 32'h55, 0, 0}, '{0, OFF_STATUS, 0, 32'h55, 0},
      '{1, OFF_ENABLE, 32'hffffffff, 0, 0}, '{0, OFF_ENABLE, 0, 32'h3f, 0},
      '{1, OFF_MCU_CTRL, 32'h2, 0, 0}, '{0, OFF_MCU_CTRL, 0, 32'h2, 0},
      '{1, OFF_ZPAGE, 32'ha5, 0, 0}, '{0, OFF_ZPAGE, 0, 32'ha5, 0},
      '{1, OFF_STACK, 32'h1234, 0, 0}, '{0, OFF_STACK, 0, 32'h1234, 0},
      '{1, OFF_STACK, 32'h0aff, 0, 0}, '{1, OFF_STATE, 32'hff, 0, 0},
      '{0, OFF_STATE, 0, 32'h0, 0}, '{1, 12'h01c, 32'h1, 0, 1}, '{0, 12'h01c, 0, 32'h0, 1},
      '{1, OFF_MCU_CTRL, 32'h0, 0, 0}, '{1, OFF_STATUS, 32'h0, 0, 0}};
    repeat (3) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(e, rows[i].e);
      if (!rows[i].w) chk(r, rows[i].x);
    end
    apb(1, OFF_ENABLE, 32'h15);
    pulse(4'h8);
    apb(0, OFF_FLAGS, 0);
    chk(r, 32'h8);
    apb(1, OFF_FLAGS, 32'h7);
    apb(0, OFF_FLAGS, 0);
    chk(r, 32'h8);
    apb(1, OFF_FLAGS, 32'h8);
    apb(0, OFF_FLAGS, 0);
    chk(r, 32'h0);
    pulse(4'h5);
    step(0, 0, 0);
    chk(a, 16'hffff);
    apb(1, OFF_STATUS, 32'h83);
    step(0, 1, 0);
    chk(a, 16'hffff);
    apb(0, OFF_STATUS, 0);
    chk(r, 32'h03);
    step(1, 0, 0);
    chk(a, 16'hffff);
    apb(0, OFF_STATUS, 0);
    chk(r, 32'h83);
    step(0, 0, 0);
    chk(a, 16'h0002);
    chk(n, 6);
    chk(h, 5);
    apb(0, OFF_STATUS, 0);
    chk(r, 32'h03);
    apb(0, OFF_FLAGS, 0);
    chk(r, 32'h4);
    apb(0, OFF_STACK, 0);
    chk(r, 32'h0afc);
    chk({u_stack.mem[16'h0aff], u_stack.mem[16'h0afe],
      u_stack.mem[16'h0afd]}, 24'h230100);
    step(0, 0, 1);
    chk(a, 16'h0123);
    chk(n, 6);
    chk(h, 5);
    apb(0, OFF_STATUS, 0);
    chk(r, 32'h83);
    apb(0, OFF_STACK, 0);
    chk(r, 32'h0aff);
    apb(1, OFF_MCU_CTRL, 32'h2);
    step(0, 0, 0);
    chk(a, BOOT_START_DEF + 16'h6);
    apb(1, OFF_STATUS, 32'h80);
    level_req <= 2'h1;
    step(0, 0, 0);
    chk(a, BOOT_START_DEF + 16'ha);
    level_req <= 2'h0;
    apb(0, OFF_STACK, 0);
    chk(r, 32'h0af9);
    step(0, 0, 1);
    chk(a, 16'h0123);
    step(0, 0, 1);
    chk(a, 16'h0123);
    apb(0, OFF_STACK, 0);
    chk(r, 32'h0aff);
    step(0, 0, 0);
    chk(a, 16'hffff);
    pulse(4'h1);
    step(0, 0, 0, 1);
    chk(a, BOOT_START_DEF + 16'h2);
    chk(n, 11);
    chk(h, 10);
    step(0, 0, 1);
    chk(a, 16'h0123);
    app_lock <= 1;
    pulse(4'h1);
    step(0, 0, 0);
    chk(a, 16'hffff);
    cur_pc <= BOOT_START_DEF + 16'h0010;
    step(0, 0, 0);
    chk(a, BOOT_START_DEF + 16'h2);
    step(0, 0, 1);
    chk(a, BOOT_START_DEF + 16'h10);
    app_lock <= 0;
    boot_lock <= 1;
    apb(1, OFF_MCU_CTRL, 32'h0);
    pulse(4'h1);
    step(0, 0, 0);
    chk(a, 16'hffff);
    cur_pc <= 16'h0123;
    step(0, 0, 0);
    chk(a, 16'h0002);
    step(0, 0, 1);
    chk(a, 16'h0123);
    boot_lock <= 0;
    ext_load <= 1;
    repeat (3) @(posedge pclk);
    chk(prog_addr, 24'ha51234);
    ext_load <= 0;
    sps <= 1;
    repeat (3) @(posedge pclk);
    chk(prog_addr, 24'ha51234);
    sps <= 0;
    repeat (3) @(posedge pclk);
    chk(prog_addr, 24'h001234);
    boot_reset_fuse <= 1;
    presetn <= 0;
    repeat (3) @(posedge pclk);
    chk(reset_vector, VEC_BASE_APP);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    chk(reset_vector, BOOT_START_DEF);
    apb(0, OFF_STATUS, 0);
    chk(r, {24'h0, STATUS_RST});
    apb(0, OFF_ENABLE, 0);
    chk(r, {26'h0, ENABLE_RST});
    apb(0, OFF_STACK, 0);
    chk(r, {16'h0, SP_RST});
    apb(0, OFF_ZPAGE, 0);
    chk(r, {24'h0, ZPAGE_RST});
    end_sim();
  end
endmodule : cpu_interrupt_entry_return_bench
